// File: cai_alarm.sv
//==========================================================================
// Calendar alarm with AXI4-Lite registers and open-drain interrupt pin
//==========================================================================
// Compares alarm settings with the running time on each second update.
// Assumes time counters and the tick run on I_CLOCK, so no synchroniser.
`timescale 1ns/1ns
module cai_alarm
  import cai_pkg::*;
#(
  parameter int ADDR_W = 8
)
(
  input  wire logic              I_CLOCK,     // 250 MHz clock
  input  wire logic              I_RST_N,     // Sync reset, active low
  input  wire logic              I_SEC_TICK,  // One-second update pulse
  input  wire cai_time_type      I_TIME,      // Current BCD time
  input  wire logic [ADDR_W-1:0] I_AWADDR,    // Write address
  input  wire logic              I_AWVALID,   // Write address valid
  output logic                   O_AWREADY,   // Write address ready
  input  wire logic [31:0]       I_WDATA,     // Write data
  input  wire logic [3:0]        I_WSTRB,     // Write strobes
  input  wire logic              I_WVALID,    // Write data valid
  output logic                   O_WREADY,    // Write data ready
  output logic [1:0]             O_BRESP,     // Write response
  output logic                   O_BVALID,    // Write response valid
  input  wire logic              I_BREADY,    // Write response ready
  input  wire logic [ADDR_W-1:0] I_ARADDR,    // Read address
  input  wire logic              I_ARVALID,   // Read address valid
  output logic                   O_ARREADY,   // Read address ready
  output logic [31:0]            O_RDATA,     // Read data
  output logic [1:0]             O_RRESP,     // Read response
  output logic                   O_RVALID,    // Read data valid
  input  wire logic              I_RREADY,    // Read data ready
  output logic                   O_INT_PIN_O, // Pin level when driven
  output logic                   O_INT_OE_N,  // Pin enable, low drives
  output logic                   O_IRQ        // Level interrupt, high
);

  //==========================================================================
  // Helpers
  //==========================================================================
  // BCD field hit: exclude bit set means the field always agrees
  function automatic logic bcd_hit(input logic [7:0] r,
                                   input logic [6:0] cur,
                                   input logic [6:0] m);
    bcd_hit = r[EXCL_BIT] | ((r[6:0] & m) == (cur & m));
  endfunction : bcd_hit

  // Register read mux; unmapped offsets answer with an error
  function automatic logic [32:0] read_reg(input logic [7:0] a,
                                           input cai_state_type s);
    read_reg = {1'b0, 32'h0};
    if (a == OFS_SECOND)
      read_reg = {1'b0, 24'h0, s.second};
    else if (a == OFS_MINUTE || a == OFS_MIN_ALIAS)
      read_reg = {1'b0, 24'h0, s.minute};
    else if (a == OFS_HOUR || a == OFS_HR_ALIAS)
      read_reg = {1'b0, 24'h0, s.hour};
    else if (a == OFS_DAY || a == OFS_DAY_ALIAS)
      read_reg = {1'b0, 24'h0, s.day};
    else if (a == OFS_CONTROL)
      read_reg = {1'b0, 31'h0, s.day_select_mode};
    else if (a == OFS_ENABLE)
      read_reg = {1'b0, 31'h0, s.alarm_irq_enable};
    else if (a == OFS_FLAG)
      read_reg = {1'b0, 31'h0, s.alarm_flag};
    else
      read_reg = {1'b1, 32'h0};
  endfunction : read_reg

  cai_state_type st;
  cai_state_type next_st;

  //==========================================================================
  // Field comparison
  //==========================================================================
  logic sec_hit;
  logic min_hit;
  logic hour_hit;
  logic day_hit;
  logic all_hit;
  logic [7:0] wr_addr;
  logic wr_go;
  logic [32:0] rd_word;

  // Seconds are seven BCD bits, hours six
  assign sec_hit  = bcd_hit(st.second, I_TIME.sec, FULL_CMP);
  assign min_hit  = bcd_hit(st.minute, I_TIME.min, FULL_CMP);
  assign hour_hit = bcd_hit(st.hour, {1'b0, I_TIME.hour}, HOUR_CMP);
  // Weekday mask hits on any shared day; month day ignores bit 6
  assign day_hit  = st.day[EXCL_BIT] |
                    (st.day_select_mode ?
                     ((st.day[6:0] & MDAY_CMP) ==
                      {1'b0, I_TIME.mday}) :
                     (|(st.day[6:0] & I_TIME.wday)));
  // All excluded gives a hit on every tick
  assign all_hit  = sec_hit & min_hit & hour_hit & day_hit;
  assign wr_addr  = st.awaddr;
  // Write goes ahead once address and data are both held and no write response is pending
  assign wr_go    = st.aw_full & st.w_full & ~st.bvalid;
  assign rd_word  = read_reg(I_ARADDR[7:0], st);

  //==========================================================================
  // Next state
  //==========================================================================
  // Bus slave, register writes, flag and pin in one pass
  always_comb
  begin
    next_st = st;
    // Capture address and data in either order
    if (I_AWVALID && st.awready)
    begin
      next_st.aw_full = 1'b1;
      next_st.awaddr  = I_AWADDR[7:0];
    end
    if (I_WVALID && st.wready)
    begin
      next_st.w_full = 1'b1;
      next_st.wdata  = I_WDATA[7:0];
      next_st.wstrb0 = I_WSTRB[0];
    end
    if (st.bvalid && I_BREADY)
      next_st.bvalid = 1'b0;
    if (wr_go)
    begin
      next_st.aw_full = 1'b0;
      next_st.w_full  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = RESP_OKAY;
      // Only lane 0 carries register bits; other lanes are ignored
      if (wr_addr == OFS_SECOND)
      begin
        if (st.wstrb0)
          next_st.second = st.wdata & SEC_WMASK;
      end
      else if (wr_addr == OFS_MINUTE || wr_addr == OFS_MIN_ALIAS)
      begin
        if (st.wstrb0)
          next_st.minute = st.wdata & SEC_WMASK;
      end
      else if (wr_addr == OFS_HOUR || wr_addr == OFS_HR_ALIAS)
      begin
        if (st.wstrb0)
          next_st.hour = st.wdata & HOUR_WMASK;
      end
      else if (wr_addr == OFS_DAY || wr_addr == OFS_DAY_ALIAS)
      begin
        if (st.wstrb0)
          next_st.day = st.wdata;
      end
      else if (wr_addr == OFS_CONTROL)
      begin
        if (st.wstrb0)
          next_st.day_select_mode = st.wdata[0];
      end
      else if (wr_addr == OFS_ENABLE)
      begin
        if (st.wstrb0)
          next_st.alarm_irq_enable = st.wdata[0];
      end
      else if (wr_addr == OFS_FLAG)
      begin
        // Writing one leaves the flag alone
        if (st.wstrb0 && !st.wdata[0])
          next_st.alarm_flag = 1'b0;
      end
      else
        next_st.bresp = RESP_SLVERR;
    end
    // A match on the tick wins over a clear in the same cycle
    if (I_SEC_TICK && all_hit)
      next_st.alarm_flag = 1'b1;
    // Read channel: one outstanding read
    if (st.rvalid && I_RREADY)
      next_st.rvalid = 1'b0;
    if (I_ARVALID && st.arready)
    begin
      next_st.rvalid = 1'b1;
      next_st.rdata  = rd_word[31:0];
      next_st.rresp  = rd_word[32] ? RESP_SLVERR : RESP_OKAY;
    end
    next_st.awready = ~next_st.aw_full;
    next_st.wready  = ~next_st.w_full;
    next_st.arready = ~next_st.rvalid;
    // Pin follows flag and enable with no timed release
    next_st.irq      = next_st.alarm_flag & next_st.alarm_irq_enable;
    next_st.pin_oe_n = ~next_st.irq;
  end

  //==========================================================================
  // State register
  //==========================================================================
  // Ready lines come up one cycle after reset release
  always_ff @(posedge I_CLOCK)
  begin
    if (!I_RST_N)
    begin
      st                  <= '0;
      st.second           <= ALARM_RESET;
      st.minute           <= ALARM_RESET;
      st.hour             <= ALARM_RESET;
      st.day              <= ALARM_RESET;
      st.pin_oe_n         <= 1'b1;
    end
    else
      st <= next_st;
  end

  //==========================================================================
  // Outputs
  //==========================================================================
  assign O_AWREADY   = st.awready;
  assign O_WREADY    = st.wready;
  assign O_BVALID    = st.bvalid;
  assign O_BRESP     = st.bresp;
  assign O_ARREADY   = st.arready;
  assign O_RVALID    = st.rvalid;
  assign O_RDATA     = st.rdata;
  assign O_RRESP     = st.rresp;
  assign O_INT_PIN_O = 1'b0;   // Open drain only ever pulls low
  assign O_INT_OE_N  = st.pin_oe_n;
  assign O_IRQ       = st.irq;

  //==========================================================================
  // Assertions
  //==========================================================================
  default clocking cb @(posedge I_CLOCK); endclocking
  default disable iff (!I_RST_N);

  sequence s_match;
    I_SEC_TICK && all_hit;
  endsequence

  sequence s_flag_clear;
    wr_go && wr_addr == OFS_FLAG && st.wstrb0 && !st.wdata[0];
  endsequence

  sequence s_enable_off;
    wr_go && wr_addr == OFS_ENABLE && st.wstrb0 && !st.wdata[0];
  endsequence

  a_flag_on_match: assert property (s_match |=> st.alarm_flag)
    else $error("Alarm flag not set on match");

  a_flag_sticky: assert property (
    st.alarm_flag &&
    !(wr_go && wr_addr == OFS_FLAG && st.wstrb0 && !st.wdata[0])
    |=> st.alarm_flag)
    else $error("Alarm flag dropped without clear");

  a_flag_only_tick: assert property (
    !st.alarm_flag && !(I_SEC_TICK && all_hit) |=> !st.alarm_flag)
    else $error("Alarm flag set without a matching tick");

  a_clear_release: assert property (
    s_flag_clear ##0 !(I_SEC_TICK && all_hit)
    |=> !st.alarm_flag && O_INT_OE_N && !O_IRQ)
    else $error("Flag clear did not release pin");

  a_enable_release: assert property (s_enable_off |=> O_INT_OE_N)
    else $error("Enable clear did not release pin");

  a_pin_drive: assert property (
    O_INT_OE_N == !(st.alarm_flag && st.alarm_irq_enable))
    else $error("Pin enable disagrees with flag and enable");

  a_all_excluded: assert property (
    I_SEC_TICK && st.second[7] && st.minute[7] && st.hour[7] &&
    st.day[7] |=> st.alarm_flag)
    else $error("All-excluded alarm missed a tick");

  a_sec_excluded: assert property (
    I_SEC_TICK && st.second[7] && min_hit && hour_hit && day_hit
    |=> st.alarm_flag)
    else $error("Seconds-excluded alarm missed a tick");

  a_alias_write: assert property (
    wr_go && wr_addr == OFS_MIN_ALIAS && st.wstrb0
    |=> st.minute == $past(st.wdata))
    else $error("Minute alias write not stored");

  a_hour_format: assert property (st.hour[6] == 1'b0)
    else $error("Hour reserved bit set");

  a_mday_bit6: assert property (
    st.day_select_mode && !st.day[7] &&
    st.day[5:0] == I_TIME.mday |-> day_hit)
    else $error("Month day compare looked at bit 6");

  a_resp_hold: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
    else $error("Write response dropped early");

  //==========================================================================
  // Stores, pin behaviour and read channel
  //==========================================================================
  // Enable written to one
  sequence s_enable_on;
    wr_go && wr_addr == OFS_ENABLE && st.wstrb0 && st.wdata[0];
  endsequence

  // Plain store to the second register
  sequence s_second_write;
    wr_go && wr_addr == OFS_SECOND && st.wstrb0;
  endsequence

  // Set and clear in one cycle: the match must win
  a_set_beats_clear: assert property (
    s_match ##0 s_flag_clear |=> st.alarm_flag)
    else $error("Clear beat a match in the same cycle");

  a_flag_write_one: assert property (
    wr_go && wr_addr == OFS_FLAG && st.wstrb0 && st.wdata[0] &&
    st.alarm_flag |=> st.alarm_flag)
    else $error("Writing one cleared the flag");

  a_tick_drives_pin: assert property (
    s_match |=> O_IRQ == st.alarm_irq_enable &&
    O_INT_OE_N == !st.alarm_irq_enable)
    else $error("Pin did not follow enable on a match");

  a_enable_drives: assert property (
    s_enable_on ##0 st.alarm_flag |=> O_IRQ && !O_INT_OE_N)
    else $error("Enable with flag set did not drive pin");

  a_irq_oe_pair: assert property (O_IRQ == !O_INT_OE_N)
    else $error("Level interrupt and pin enable disagree");

  // Only a flag or enable write may let the pin go
  a_no_timed_release: assert property (
    O_IRQ && !(wr_go && (wr_addr == OFS_FLAG || wr_addr == OFS_ENABLE))
    |=> O_IRQ)
    else $error("Pin let go without a flag or enable write");

  a_second_store: assert property (
    s_second_write |=> st.second == $past(st.wdata))
    else $error("Second register not stored");

  // Hour bit six is spare and always reads zero
  a_hour_store: assert property (
    wr_go && (wr_addr == OFS_HOUR || wr_addr == OFS_HR_ALIAS) &&
    st.wstrb0 |=> st.hour[7] == $past(st.wdata[7]) &&
    st.hour[5:0] == $past(st.wdata[5:0]))
    else $error("Hour register not stored");

  a_day_alias: assert property (
    wr_go && wr_addr == OFS_DAY_ALIAS && st.wstrb0
    |=> st.day == $past(st.wdata))
    else $error("Day alias write not stored");

  a_mode_store: assert property (
    wr_go && wr_addr == OFS_CONTROL && st.wstrb0
    |=> st.day_select_mode == $past(st.wdata[0]))
    else $error("Day select mode not stored");

  a_week_any_day: assert property (
    !st.day_select_mode && !st.day[7] &&
    (st.day[6:0] & I_TIME.wday) != 7'h00 |-> day_hit)
    else $error("Weekday mask missed a listed day");

  a_week_other_day: assert property (
    !st.day_select_mode && !st.day[7] &&
    (st.day[6:0] & I_TIME.wday) == 7'h00 |-> !day_hit)
    else $error("Weekday mask hit an unlisted day");

  a_mday_miss: assert property (
    st.day_select_mode && !st.day[7] &&
    st.day[5:0] != I_TIME.mday |-> !day_hit)
    else $error("Month day hit on a different day");

  a_field_excluded: assert property (
    st.second[7] && st.minute[7] |-> sec_hit && min_hit)
    else $error("Excluded field still took part");

  // Read data must not move while the host has not taken it
  a_rdata_hold: assert property (
    O_RVALID && !I_RREADY |=> O_RVALID && $stable(O_RDATA))
    else $error("Read data changed before it was taken");

endmodule : cai_alarm

// File: cai_host.sv
// ========================================
// Host model for the alarm block
// ========================================
// AXI4-Lite master tasks and the pulled-up interrupt line.
// Assumes one clock shared with the block; the bench calls the tasks.
`timescale 1ns/1ns
module cai_host
(
  input  wire logic        i_clk,     // Bus clock
  output logic [7:0]       o_awaddr,  // Write address
  output logic             o_awvalid, // Write address valid
  input  wire logic        i_awready, // Write address ready
  output logic [31:0]      o_wdata,   // Write data
  output logic [3:0]       o_wstrb,   // Write strobes
  output logic             o_wvalid,  // Write data valid
  input  wire logic        i_wready,  // Write data ready
  input  wire logic [1:0]  i_bresp,   // Write response
  input  wire logic        i_bvalid,  // Write response valid
  output logic             o_bready,  // Write response ready
  output logic [7:0]       o_araddr,  // Read address
  output logic             o_arvalid, // Read address valid
  input  wire logic        i_arready, // Read address ready
  input  wire logic [31:0] i_rdata,   // Read data
  input  wire logic [1:0]  i_rresp,   // Read response
  input  wire logic        i_rvalid,  // Read data valid
  output logic             o_rready,  // Read data ready
  input  wire logic        i_pin_o,   // Pin level when driven
  input  wire logic        i_oe_n,    // Pin enable, low drives
  output logic             o_line     // Line as the host sees it
);
  // Pull-up wins whenever the block lets go of the line
  assign o_line = i_oe_n ? 1'b1 : i_pin_o;

  // Idle bus at time zero
  initial
  begin
    {o_awaddr, o_awvalid, o_wdata, o_wvalid} = '0;
    {o_bready, o_araddr, o_arvalid, o_rready} = '0;
    o_wstrb = 4'hf;
  end

  // One write; each channel drops once it is taken
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    output logic [1:0] r);
    @(posedge i_clk);
    o_awaddr  <= a;
    o_wdata   <= {24'h000000, d};
    o_awvalid <= 1'b1;
    o_wvalid  <= 1'b1;
    o_bready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (o_awvalid && i_awready) o_awvalid <= 1'b0;
      if (o_wvalid && i_wready) o_wvalid <= 1'b0;
    end
    while (!i_bvalid);
    r = i_bresp;
    o_bready <= 1'b0;
  endtask : wr

  // One read; rready held until the data is seen
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    @(posedge i_clk);
    o_araddr  <= a;
    o_arvalid <= 1'b1;
    o_rready  <= 1'b1;
    do
    begin
      @(posedge i_clk);
      if (o_arvalid && i_arready) o_arvalid <= 1'b0;
    end
    while (!i_rvalid);
    d = i_rdata;
    r = i_rresp;
    o_rready <= 1'b0;
  endtask : rd
endmodule : cai_host

// File: cai_pkg.sv
//==========================================================================
// Package for the calendar alarm interrupt block
//==========================================================================
// Holds register offsets, field layouts, reset values and carrier types.
// Assumes a running time/calendar counter on the same clock feeding BCD.
//
// Contract
// - Second register: exclude, 3-bit tens, 4-bit units
// - Minute register: exclude, 3-bit tens, 4-bit units
// - Hour register: exclude, 2-bit tens, 4-bit units
// - Weekday mode: seven-bit mask, Sunday bit zero
// - Month-day mode: 2-bit tens, 4-bit units BCD
// - Set exclude bit removes that field from comparison
// - All fields excluded: alarm every second
// - Seconds excluded: alarm each matching second
// - Match sets flag; stays until host clears
// - Flag with enable drives interrupt pin low
// - Writing flag zero clears it, releases pin
// - Writing enable zero releases pin regardless
// - Alias locations reach minute, hour, day storage
package cai_pkg;

  //==========================================================================
  // Register offsets (byte addresses)
  //==========================================================================
  localparam logic [7:0] OFS_SECOND    = 8'h00;
  localparam logic [7:0] OFS_MINUTE    = 8'h04;
  localparam logic [7:0] OFS_HOUR      = 8'h08;
  localparam logic [7:0] OFS_DAY       = 8'h0c;
  localparam logic [7:0] OFS_MIN_ALIAS = 8'h10;
  localparam logic [7:0] OFS_HR_ALIAS  = 8'h14;
  localparam logic [7:0] OFS_DAY_ALIAS = 8'h18;
  localparam logic [7:0] OFS_CONTROL   = 8'h1c;
  localparam logic [7:0] OFS_ENABLE    = 8'h20;
  localparam logic [7:0] OFS_FLAG      = 8'h24;

  //==========================================================================
  // Field layout
  //==========================================================================
  localparam int         EXCL_BIT    = 7;
  localparam logic [7:0] SEC_WMASK   = 8'hff;
  localparam logic [7:0] HOUR_WMASK  = 8'hbf;
  localparam logic [6:0] FULL_CMP    = 7'h7f;
  localparam logic [6:0] HOUR_CMP    = 7'h3f;
  localparam logic [6:0] MDAY_CMP    = 7'h3f;

  //==========================================================================
  // Reset values and bus answers
  //==========================================================================
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Running time in BCD, wday one-hot with Sunday in bit 0
  typedef struct packed {
    logic [6:0] sec;
    logic [6:0] min;
    logic [5:0] hour;
    logic [6:0] wday;
    logic [5:0] mday;
  } cai_time_type;

  // Whole state of the block
  typedef struct packed {
    logic [7:0]  second;
    logic [7:0]  minute;
    logic [7:0]  hour;
    logic [7:0]  day;
    logic        day_select_mode;
    logic        alarm_irq_enable;
    logic        alarm_flag;
    logic        irq;
    logic        pin_oe_n;
    logic        aw_full;
    logic        w_full;
    logic [7:0]  awaddr;
    logic [7:0]  wdata;
    logic        wstrb0;
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } cai_state_type;

endpackage : cai_pkg

// File: tb_calendar_alarm_interrupt.sv
// ========================================
// Testbench for the calendar alarm block
// ========================================
// Drives time and tick directly; registers go through the host model.
// Assumes the package offsets and the registered interrupt outputs.
`timescale 1ns/1ns
module tb_calendar_alarm_interrupt
  import cai_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tick = 1'b0;
  cai_time_type tm = '0;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pin_o, oe_n, line, irq;
  int n_errors = 0;
  int checks = 0;

  // 250 MHz clock
  always #2 clk = ~clk;

  cai_alarm DUT (.I_CLOCK(clk), .I_RST_N(rst_n), .I_SEC_TICK(tick),
    .I_TIME(tm), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
    .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb),
    .I_WVALID(wvalid), .O_WREADY(wready), .O_BRESP(bresp),
    .O_BVALID(bvalid), .I_BREADY(bready), .I_ARADDR(araddr),
    .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
    .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
    .O_INT_PIN_O(pin_o), .O_INT_OE_N(oe_n), .O_IRQ(irq));

  cai_host host (.i_clk(clk), .o_awaddr(awaddr), .o_awvalid(awvalid),
    .i_awready(awready), .o_wdata(wdata), .o_wstrb(wstrb),
    .o_wvalid(wvalid), .i_wready(wready), .i_bresp(bresp),
    .i_bvalid(bvalid), .o_bready(bready), .o_araddr(araddr),
    .o_arvalid(arvalid), .i_arready(arready), .i_rdata(rdata),
    .i_rresp(rresp), .i_rvalid(rvalid), .o_rready(rready),
    .i_pin_o(pin_o), .i_oe_n(oe_n), .o_line(line));

  task automatic stop_test;
    if (n_errors == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  function automatic cai_time_type mk(input logic [6:0] s,
    input logic [6:0] w, input logic [5:0] d);
    return {s, 7'h59, 6'h18, w, d};
  endfunction : mk

  // Register helpers; writes to mapped places must answer okay
  task automatic w(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] r;
    host.wr(a, d, r);
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : w

  task automatic rx(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] d;
    logic [1:0] r;
    host.rd(a, d, r);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, RESP_OKAY});
  endtask : rx

  // Flag by register, then level interrupt and line after settling
  task automatic st(input logic f, input logic en);
    rx(OFS_FLAG, {7'h0, f});
    #1;
    chk({30'h0, irq, line}, {30'h0, f & en, !(f & en)});
  endtask : st

  // Time shows the new value in the tick cycle
  task automatic tk(input cai_time_type t);
    @(posedge clk);
    tm <= t;
    @(posedge clk);
    tick <= 1'b1;
    @(posedge clk);
    tick <= 1'b0;
  endtask : tk

  task automatic t_regs;
    logic [31:0] tab [7] = '{32'h00d900d9, 32'h04590459, 32'h08ff08bf,
      32'h0c7f0c7f, 32'h10420442, 32'h14230823, 32'h18310c31};
    logic [31:0] d;
    logic [1:0] r;
    foreach (tab[i])
    begin
      w(tab[i][31:24], tab[i][23:16]);
      rx(tab[i][15:8], tab[i][7:0]);
    end
    host.wr(8'h28, 8'h01, r);
    chk({30'h0, r}, {30'h0, RESP_SLVERR});
    host.rd(8'h28, d, r);
    chk({d[29:0], r}, {30'h0, RESP_SLVERR});
  endtask : t_regs

  // Alarm set up in the order the host must keep
  task automatic arm(input logic [7:0] s, input logic [7:0] m,
                     input logic [7:0] h, input logic [7:0] d,
                     input logic md);
    w(OFS_ENABLE, 8'h00);
    w(OFS_SECOND, s);
    w(OFS_MINUTE, m);
    w(OFS_HOUR, h);
    w(OFS_DAY, d);
    w(OFS_CONTROL, {7'h00, md});
    w(OFS_FLAG, 8'h00);
    w(OFS_ENABLE, 8'h01);
  endtask : arm

  task automatic t_time;
    arm(8'h30, 8'h59, 8'h18, 8'h80, 1'b0);
    tm <= mk(7'h30, 7'h01, 6'h01);
    repeat (4) @(posedge clk);
    st(1'b0, 1'b1);
    tk(mk(7'h29, 7'h02, 6'h02));
    st(1'b0, 1'b1);
    tk(mk(7'h30, 7'h04, 6'h03));
    st(1'b1, 1'b1);
    tk(mk(7'h31, 7'h04, 6'h03));
    w(OFS_FLAG, 8'h01);
    st(1'b1, 1'b1);
    w(OFS_FLAG, 8'h00);
    st(1'b0, 1'b1);
    tk(mk(7'h30, 7'h08, 6'h04));
    w(OFS_ENABLE, 8'h00);
    st(1'b1, 1'b0);
    w(OFS_ENABLE, 8'h01);
    st(1'b1, 1'b1);
  endtask : t_time

  // Weekday mask Monday to Friday, seconds excluded
  task automatic t_week;
    arm(8'h80, 8'h59, 8'h18, 8'h3e, 1'b0);
    for (int i = 0; i < 7; i++)
    begin
      w(OFS_FLAG, 8'h00);
      tk(mk(7'(i), 7'(1 << i), 6'h01));
      st(i > 0 && i < 6, 1'b1);
    end
  endtask : t_week

  // Everything excluded: each tick sets the flag
  task automatic t_all;
    arm(8'h80, 8'h80, 8'h80, 8'h80, 1'b0);
    repeat (3)
    begin
      w(OFS_FLAG, 8'h00);
      st(1'b0, 1'b1);
      tk(mk(7'h00, 7'h00, 6'h00));
      st(1'b1, 1'b1);
    end
  endtask : t_all

  // Day 15 with the spare bit six set
  task automatic t_mday;
    arm(8'h80, 8'h80, 8'h80, 8'h55, 1'b1);
    rx(OFS_CONTROL, 8'h01);
    tk(mk(7'h00, 7'h20, 6'h05));
    st(1'b0, 1'b1);
    tk(mk(7'h00, 7'h20, 6'h15));
    st(1'b1, 1'b1);
  endtask : t_mday

  // Reset in mid-run clears settings, flag and pin
  task automatic t_rst;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    st(1'b0, 1'b0);
    rx(OFS_DAY, ALARM_RESET);
  endtask : t_rst

  // Main sequence
  initial
  begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs;
    t_time;
    t_week;
    t_all;
    t_mday;
    t_rst;
    stop_test;
  end

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    #200000;
    n_errors++;
    stop_test;
  end
endmodule : tb_calendar_alarm_interrupt
